// ===== include/router_pkg.sv
// Constants shared by the input terminal router and its source decoders.
package router_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int TERM_N = 7;
    localparam int DIGIT_W = 4;
    localparam int LATCH_N = 3;
    localparam int NEAR_PAIR_N = 3;
    localparam int FUNC_N = 4;

    localparam logic [3:0] ADDR_NEAR_CFG = 4'h0;
    localparam logic [3:0] ADDR_INPUT_CFG = 4'h1;
    localparam logic [3:0] ADDR_RESTART = 4'h2;
    localparam logic [3:0] ADDR_NEAR_ACT = 4'h3;
    localparam logic [3:0] ADDR_INPUT_ACT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;

    localparam logic [15:0] NEAR_CFG_RESET = 16'h0000;
    localparam logic [15:0] INPUT_CFG_RESET = 16'h6543;
    localparam logic [15:0] NEAR_CFG_MAX = 16'h0333;
    localparam logic [15:0] NEAR_RESERVED_MASK = 16'hFFF0;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam logic [3:0] NEAR_DIGIT_MAX = 4'h3;

    localparam int RESTART_BIT = 0;
    localparam int STAT_HOMING = 0;
    localparam int STAT_EXT_LATCH_ONE = 1;
    localparam int STAT_NEAR_IN = 4;
    localparam int STAT_PENDING = 5;

    localparam logic [3:0] CODE_FORCE_ON = 4'h7;
    localparam logic [3:0] CODE_FORCE_OFF = 4'h8;
    localparam logic [3:0] CODE_INV_BASE = 4'h9;
    localparam logic [3:0] CODE_LATCH_LO = 4'h4;
    localparam logic [3:0] CODE_LATCH_INV_LO = 4'hD;
    localparam logic [3:0] CODE_LATCH_INV_HI = 4'hF;

    typedef enum logic [1:0] {
        NEAR_OFF = 2'b00,
        NEAR_PAIR_A = 2'b01,
        NEAR_PAIR_B = 2'b10,
        NEAR_PAIR_C = 2'b11
    } near_route_t;
endpackage

// ===== include/route_sel_if.sv
// Carrier between the router and one source decoder.
`timescale 1ns/10ps
interface route_sel_if;
    logic [router_pkg::DIGIT_W-1:0] code;
    logic [router_pkg::TERM_N-1:0] terms;
    logic level;
    modport dec (input code, input terms, output level);
    modport user (output code, output terms, input level);
endinterface

// ===== hdl/input_source_decoder.sv
// Decodes one selection digit into the level of one internal function.
`timescale 1ns/10ps
module input_source_decoder #(
    parameter bit IS_HOMING = 1'b0
) (
    route_sel_if.dec bus
);
    logic [3:0] inv_idx;

    assign inv_idx = bus.code - router_pkg::CODE_INV_BASE;

    always_comb begin
        bus.level = 1'b0;
        if (bus.code == router_pkg::CODE_FORCE_ON) begin
            bus.level = 1'b1;
        end else if (bus.code == router_pkg::CODE_FORCE_OFF) begin
            bus.level = 1'b0;
        end else if (IS_HOMING) begin
            if (bus.code < router_pkg::CODE_FORCE_ON) begin
                bus.level = bus.terms[bus.code[2:0]];
            end else begin
                bus.level = ~bus.terms[inv_idx[2:0]];
            end
        end else begin
            if (bus.code >= router_pkg::CODE_LATCH_LO &&
                    bus.code < router_pkg::CODE_FORCE_ON) begin
                bus.level = bus.terms[bus.code[2:0]];
            end else if (bus.code >= router_pkg::CODE_LATCH_INV_LO &&
                    bus.code <= router_pkg::CODE_LATCH_INV_HI) begin
                bus.level = ~bus.terms[inv_idx[2:0]];
            end else begin
                bus.level = 1'b0;
            end
        end
    end
endmodule // input_source_decoder

// ===== hdl/io_terminal_signal_router.sv
// Input terminal to function router and near-position output router.
// Notes on behaviour
// - The input selection word takes any 16-bit value, resets to 6543 and a written value takes effect only at restart.
// - Homing decel codes 0 to 6 pick terminals 13, 7, 8, 9, 10, 11, 12; code 7 forces on and code 8 forces off.
// - Homing decel codes 9 to F pick the same seven terminals in order but feed the inverted level.
// - Latch one codes 4 to 6 pick terminals 10 to 12, D to F their inverse, 7 forces on, everything else off.
// - The near route word accepts 0000 to 0003, resets to 0000, applies at restart and only its low digit acts.
// - Near route digit 0 drives no output pair, while 1, 2 and 3 drive one of the three pairs.
`timescale 1ns/10ps
module io_terminal_signal_router #(
    parameter int TERM_N = router_pkg::TERM_N,
    parameter int NEAR_PAIR_N = router_pkg::NEAR_PAIR_N
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [router_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [router_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [router_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [TERM_N-1:0] in_term,
    input wire logic near_pos,
    output logic homing_decel_switch,
    output logic ext_latch_one,
    output logic ext_latch_two,
    output logic ext_latch_three,
    output logic [NEAR_PAIR_N-1:0] near_out
);
    logic [15:0] near_output_route_cfg_reg;
    logic [15:0] input_route_cfg_five_reg;
    logic [15:0] near_active_reg;
    logic [15:0] input_active_reg;
    logic [15:0] rdata_reg;
    logic homing_reg;
    logic [router_pkg::LATCH_N-1:0] latch_reg;
    logic [NEAR_PAIR_N-1:0] near_out_reg;
    logic [router_pkg::FUNC_N-1:0] func_level;
    logic [15:0] rdata_next;
    logic wr_near;
    logic wr_input;
    logic restart_req;
    logic near_ok;
    logic pending;
    router_pkg::near_route_t near_route;
    logic near_enabled;
    logic [1:0] near_pair_idx;
    logic [15:0] status_word;

    route_sel_if sel_if[router_pkg::FUNC_N] ();

    // Write strobes; a restart needs its enable bit set.
    assign wr_near = reg_wr && reg_addr == router_pkg::ADDR_NEAR_CFG;
    assign wr_input = reg_wr && reg_addr == router_pkg::ADDR_INPUT_CFG;
    assign restart_req = reg_wr && reg_addr == router_pkg::ADDR_RESTART &&
        reg_wdata[router_pkg::RESTART_BIT];

    // Near words outside the legal range are dropped whole.
    assign near_ok = reg_wdata <= router_pkg::NEAR_CFG_MAX &&
        (reg_wdata & router_pkg::NEAR_RESERVED_MASK) == 16'h0000 &&
        reg_wdata[3:0] <= router_pkg::NEAR_DIGIT_MAX;
    assign pending = near_output_route_cfg_reg != near_active_reg ||
        input_route_cfg_five_reg != input_active_reg;
    assign near_route = router_pkg::near_route_t'(near_active_reg[1:0]);

    // Stored setting words, written by software.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            input_route_cfg_five_reg <= router_pkg::INPUT_CFG_RESET;
        end else if (wr_input) begin
            input_route_cfg_five_reg <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            near_output_route_cfg_reg <= router_pkg::NEAR_CFG_RESET;
        end else if (wr_near && near_ok) begin
            near_output_route_cfg_reg <= reg_wdata;
        end
    end

    // Working copies, loaded only by a restart.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            input_active_reg <= router_pkg::INPUT_CFG_RESET;
        end else if (restart_req) begin
            input_active_reg <= input_route_cfg_five_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            near_active_reg <= router_pkg::NEAR_CFG_RESET;
        end else if (restart_req) begin
            near_active_reg <= near_output_route_cfg_reg;
        end
    end

    // One decoder per function; digit 0 is homing, the rest are latches.
    generate
        for (genvar g = 0; g < router_pkg::FUNC_N; g++) begin : g_dec
            assign sel_if[g].code =
                input_active_reg[g*router_pkg::DIGIT_W +: router_pkg::DIGIT_W];
            assign sel_if[g].terms = in_term;
            assign func_level[g] = sel_if[g].level;
            input_source_decoder #(
                .IS_HOMING(g == 0)
            ) u_dec (
                .bus(sel_if[g])
            );
        end
    endgenerate

    // Routed function levels, one flop each.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            homing_reg <= 1'b0;
        end else begin
            homing_reg <= func_level[0];
        end
    end

    generate
        for (genvar k = 0; k < router_pkg::LATCH_N; k++) begin : g_latch
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    latch_reg[k] <= 1'b0;
                end else begin
                    latch_reg[k] <= func_level[k+1];
                end
            end
        end
    endgenerate

    // Pair index from the active near digit; digit 0 disconnects.
    always_comb begin
        near_enabled = 1'b1;
        near_pair_idx = 2'b00;
        unique case (near_route)
            router_pkg::NEAR_OFF: begin
                near_enabled = 1'b0;
            end
            router_pkg::NEAR_PAIR_A: begin
                near_pair_idx = 2'b00;
            end
            router_pkg::NEAR_PAIR_B: begin
                near_pair_idx = 2'b01;
            end
            router_pkg::NEAR_PAIR_C: begin
                near_pair_idx = 2'b10;
            end
        endcase
    end

    // Near-position routing to the output terminal pairs.
    generate
        for (genvar p = 0; p < NEAR_PAIR_N; p++) begin : g_near
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    near_out_reg[p] <= 1'b0;
                end else begin
                    near_out_reg[p] <= near_pos && near_enabled &&
                        near_pair_idx == 2'(p);
                end
            end
        end
    endgenerate

    // Status word: routed levels, raw near input and pending restart.
    always_comb begin
        status_word = router_pkg::READ_ZERO;
        status_word[router_pkg::STAT_HOMING] = homing_reg;
        status_word[router_pkg::STAT_EXT_LATCH_ONE +: router_pkg::LATCH_N] = latch_reg;
        status_word[router_pkg::STAT_NEAR_IN] = near_pos;
        status_word[router_pkg::STAT_PENDING] = pending;
    end

    // Read decode; unmapped addresses read zero.
    always_comb begin
        rdata_next = router_pkg::READ_ZERO;
        unique case (reg_addr)
            router_pkg::ADDR_NEAR_CFG: begin
                rdata_next = near_output_route_cfg_reg;
            end
            router_pkg::ADDR_INPUT_CFG: begin
                rdata_next = input_route_cfg_five_reg;
            end
            router_pkg::ADDR_NEAR_ACT: begin
                rdata_next = near_active_reg;
            end
            router_pkg::ADDR_INPUT_ACT: begin
                rdata_next = input_active_reg;
            end
            router_pkg::ADDR_RESTART: begin
                rdata_next = router_pkg::READ_ZERO;
            end
            router_pkg::ADDR_STATUS: begin
                rdata_next = status_word;
            end
            default: begin
                rdata_next = router_pkg::READ_ZERO;
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= router_pkg::READ_ZERO;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= router_pkg::READ_ZERO;
        end
    end

    assign reg_rdata = rdata_reg;
    assign homing_decel_switch = homing_reg;
    assign ext_latch_one = latch_reg[0];
    assign ext_latch_two = latch_reg[1];
    assign ext_latch_three = latch_reg[2];
    assign near_out = near_out_reg;
endmodule // io_terminal_signal_router

// ===== tb/io_terminal_signal_router_properties.sv
// Concurrent checks on the ports of the terminal router.
`timescale 1ns/10ps
module io_terminal_signal_router_properties #(
    parameter int TERM_N = 7,
    parameter int NEAR_PAIR_N = 3
) (
    input logic mclk,
    input logic sys_rst,
    input logic [router_pkg::ADDR_W-1:0] reg_addr,
    input logic [router_pkg::DATA_W-1:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [router_pkg::DATA_W-1:0] reg_rdata,
    input logic [TERM_N-1:0] in_term,
    input logic near_pos,
    input logic homing_decel_switch,
    input logic ext_latch_one,
    input logic ext_latch_two,
    input logic ext_latch_three,
    input logic [NEAR_PAIR_N-1:0] near_out
);
    logic fresh_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fresh_reg <= 1'b1;
        end else if (reg_wr && reg_addr == router_pkg::ADDR_RESTART) begin
            fresh_reg <= 1'b0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence near_wr_s;
        reg_wr && reg_addr == router_pkg::ADDR_NEAR_CFG
            && reg_wdata[15:4] == 12'h000 && reg_wdata[3:0] <= 4'h3;
    endsequence
    sequence in_wr_s;
        reg_wr && reg_addr == router_pkg::ADDR_INPUT_CFG;
    endsequence
    AST_FACT_HOMING: assert property (fresh_reg && !$past(sys_rst)
        |-> homing_decel_switch == $past(in_term[3])) else $error("homing");
    AST_FACT_LATCH: assert property (fresh_reg && !$past(sys_rst)
        |-> {ext_latch_three, ext_latch_two, ext_latch_one}
        == $past(in_term[6:4])) else $error("latch");
    AST_FACT_NEAR: assert property (fresh_reg
        |-> near_out == '0) else $error("near factory");
    AST_NEAR_ONEHOT: assert property ($onehot0(near_out))
        else $error("near pairs");
    AST_NEAR_SRC: assert property (near_out != '0 |-> $past(near_pos))
        else $error("near source");
    AST_NEAR_RB: assert property (near_wr_s ##2
        (reg_rd && reg_addr == router_pkg::ADDR_NEAR_CFG)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("near word");
    AST_IN_RB: assert property (in_wr_s ##2
        (reg_rd && reg_addr == router_pkg::ADDR_INPUT_CFG)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("input word");
    AST_RST_OUT: assert property (disable iff (1'b0) sys_rst
        |=> near_out == '0 && !homing_decel_switch && !ext_latch_one)
        else $error("reset outputs");
endmodule // io_terminal_signal_router_properties
bind io_terminal_signal_router io_terminal_signal_router_properties #(
    .TERM_N(TERM_N), .NEAR_PAIR_N(NEAR_PAIR_N)) u_props (.*);

// ===== tb/terminal_switches.sv
// Switch and sensor lines that feed the router terminals.
`timescale 1ns/10ps
module terminal_switches (
    input logic mclk,
    input logic [6:0] set_term,
    input logic set_near,
    output logic [6:0] in_term,
    output logic near_pos
);
    always @(posedge mclk) begin
        in_term <= set_term;
        near_pos <= set_near;
    end
endmodule // terminal_switches

// ===== tb/test_io_terminal_signal_router.sv
// Self-checking bench for the terminal router.
`timescale 1ns/10ps
module test_io_terminal_signal_router;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic set_near = 1'b0;
    logic [6:0] set_term = 7'h00;
    logic [15:0] reg_rdata, rnd = 16'h000C;
    logic [6:0] in_term;
    logic [2:0] near_out;
    logic near_pos, hd_o, l1, l2, l3, rd_d;
    logic [31:0] exp_q[$];
    logic [31:0] note;
    int failures = 0;
    int cmp_count = 0;
    initial forever #12.5 mclk = ~mclk;
    io_terminal_signal_router u_io_terminal_signal_router (.mclk(mclk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_term(in_term), .near_pos(near_pos), .homing_decel_switch(hd_o),
        .ext_latch_one(l1), .ext_latch_two(l2), .ext_latch_three(l3),
        .near_out(near_out));
    terminal_switches u_terminal_switches (.mclk(mclk), .set_term(set_term),
        .set_near(set_near), .in_term(in_term), .near_pos(near_pos));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic hd_f(input logic [3:0] c, input logic [6:0] t);
        if (c < 4'h7) return t[c];
        if (c == 4'h7) return 1'b1;
        if (c == 4'h8) return 1'b0;
        return ~t[c - 4'h9];
    endfunction
    function automatic logic lt_f(input logic [3:0] c, input logic [6:0] t);
        if (c inside {4'h4, 4'h5, 4'h6}) return t[c];
        if (c == 4'h7) return 1'b1;
        if (c >= 4'hD) return ~t[c - 4'h9];
        return 1'b0;
    endfunction
    function automatic logic [15:0] exp_f(input logic [15:0] w,
            input logic [6:0] t);
        return {12'h000, lt_f(w[15:12], t), lt_f(w[11:8], t),
            lt_f(w[7:4], t), hd_f(w[3:0], t)};
    endfunction
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, m);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({m, e});
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    task automatic route(input logic [15:0] w);
        wr(router_pkg::ADDR_INPUT_CFG, w);
        wr(router_pkg::ADDR_RESTART, 16'h0001);
        rnd = lfsr(rnd);
        set_term <= rnd[6:0];
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({12'h000, l3, l2, l1, hd_o}, exp_f(w, rnd[6:0]));
        rd(router_pkg::ADDR_STATUS, exp_f(w, rnd[6:0]), 16'h003F);
    endtask
    always @(posedge mclk) rd_d <= reg_rd;
    always @(negedge mclk) begin
        if (rd_d === 1'b1) begin
            note = exp_q.pop_front();
            chk(reg_rdata & note[31:16], note[15:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        rnd = lfsr(rnd);
        set_term <= rnd[6:0];
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk({12'h000, l3, l2, l1, hd_o},
            exp_f(16'h6543, rnd[6:0]));
        rd(router_pkg::ADDR_INPUT_CFG, 16'h6543, 16'hFFFF);
        rd(router_pkg::ADDR_NEAR_CFG, 16'h0000, 16'hFFFF);
        route(16'h6543);
        wr(router_pkg::ADDR_INPUT_CFG, 16'h1234);
        rd(router_pkg::ADDR_INPUT_CFG, 16'h1234, 16'hFFFF);
        rd(router_pkg::ADDR_STATUS, 16'h0020, 16'h0020);
        rd(router_pkg::ADDR_INPUT_ACT, 16'h6543, 16'hFFFF);
        for (int c = 0; c < 16; c++) route({4{4'(c)}});
        for (int c = 0; c < 16; c++) route(16'h0987 ^ {4{4'(c)}});
        repeat (8) route(lfsr(rnd));
        $display("routing test done");
        for (int d = 0; d < 4; d++) begin
            wr(router_pkg::ADDR_NEAR_CFG, 16'(d));
            rd(router_pkg::ADDR_NEAR_CFG, 16'(d), 16'hFFFF);
            wr(router_pkg::ADDR_NEAR_CFG, 16'h0010);
            wr(router_pkg::ADDR_NEAR_CFG, 16'h0004);
            rd(router_pkg::ADDR_NEAR_CFG, 16'(d), 16'hFFFF);
            wr(router_pkg::ADDR_RESTART, 16'h0001);
            set_near <= 1'b1;
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            chk(16'(near_out), d == 0 ? 16'h0 : 16'h1 << (d - 1));
            set_near <= 1'b0;
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            chk(16'(near_out), 16'h0000);
            rd(router_pkg::ADDR_NEAR_ACT, 16'(d), 16'hFFFF);
        end
        $display("near test done");
        give_verdict();
    end
endmodule // test_io_terminal_signal_router
